/* core/hpidc_pkg.sv */
// Package of offsets, field positions and reset values for the id/config bank
package hpidc_pkg;
  localparam logic [7:0] HPIDC_OFF_SIGNATURE = 8'h00;
  localparam logic [7:0] HPIDC_OFF_PID_LOW   = 8'h03;
  localparam logic [7:0] HPIDC_OFF_PID_HIGH  = 8'h04;
  localparam logic [7:0] HPIDC_OFF_FEATURE   = 8'h05;
  localparam logic [7:0] HPIDC_SIGNATURE_VAL = 8'h55;
  // Identity defaults are arbitrary neutral values
  localparam logic [7:0] HPIDC_PID_LOW_RST   = 8'h5a;
  localparam logic [7:0] HPIDC_PID_HIGH_RST  = 8'h3c;
  localparam logic [7:0] HPIDC_HS_XOR_MASK   = 8'h02;
  localparam int HPIDC_BIT_STRING = 7;
  localparam int HPIDC_BIT_SERIAL = 6;
  localparam int HPIDC_BIT_LPDIS  = 5;
  localparam int HPIDC_BIT_RSV_HI = 4;
  localparam int HPIDC_BIT_GANG   = 3;
  localparam int HPIDC_BIT_PMOFF  = 2;
  localparam int HPIDC_BIT_RSV_RW = 1;
  localparam int HPIDC_BIT_RSV_LO = 0;
  // Writable bits of the feature byte: 7,6,5,3,2,1
  localparam logic [7:0] HPIDC_FEAT_WMASK = 8'hee;
  localparam logic [7:0] HPIDC_FEAT_RST   = 8'h10;
endpackage

/* core/hpidc_bank.sv */
// Product id bytes and hub feature configuration register bank
`timescale 1ns/1ps
// Overview of operation
// - The SuperSpeed descriptor reports the low product id byte as stored.
// - The USB 2.0 descriptor reports the low byte XORed with 02h.
// - Both one-time ids nonzero makes id bytes read-only, reading the ids.
// - Bit 7 (default 0) makes the language and string registers writable.
// - Bit 6 (default 0) makes the serial number registers writable.
// - Bit 5 at 1 disables U1/U2 initiation and acceptance on all ports.
// - A forced link power accept allows U1/U2 until reset or disconnect.
// - Bits 5,3,2 load from EEPROM in EEPROM mode, else the host writes them.
// - Bit 3 is captured from the gang strap once the synchronised straps have settled after reset.
// - Gang 0 powers ports one by one; gang 1 drives all from the port-1 pin.
// - Bit 2 comes from the power strap; 1 disables power and overcurrent.
// - Reserved bit 4 is read-only and reads 1.
// - Reserved bit 0 is read-only and reads 0.
// - An EEPROM load is aborted unless its first byte equals 55h.
module hpidc_bank
  import hpidc_pkg::*;
#(
  parameter int NPORT = 2
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             eeprom_mode,
  input  wire logic             wr_en,
  input  wire logic [7:0]       wr_addr,
  input  wire logic [7:0]       wr_data,
  input  wire logic             ee_en,
  input  wire logic [7:0]       ee_addr,
  input  wire logic [7:0]       ee_data,
  input  wire logic [7:0]       rd_addr,
  output logic [7:0]            rd_data,
  input  wire logic [15:0]      otp_vid,
  input  wire logic [15:0]      otp_pid,
  input  wire logic             gang_select_strap_pin,
  input  wire logic             power_mgmt_strap_pin,
  input  wire logic             force_lpm_accept_seen,
  input  wire logic             upstream_disconnect,
  input  wire logic [NPORT-1:0] port_power_req,
  output logic [7:0]            ss_pid_low,
  output logic [7:0]            hs_pid_low,
  output logic [7:0]            pid_high,
  output logic                  string_write_enable,
  output logic                  serial_write_enable,
  output logic                  u1u2_allowed,
  output logic                  overcurrent_report_en,
  output logic [NPORT-1:0]      port_power_control_pins
);
  import hpidc_pkg::*;

  // Gang logic is laid out for at most eight ports
  if (NPORT < 1 || NPORT > 8) begin : g_nport_check
    $error("NPORT out of range");
  end

  logic [7:0] pid_low_reg, pid_high_reg, feat_reg;
  logic [2:0] gang_sync_reg, pm_sync_reg;
  logic [2:0] strap_fill_reg;
  logic       strap_pending_reg;
  logic       flpma_reg;
  logic       sig_ok_reg;
  logic       ee_first_seen_reg;
  logic [7:0] rd_next;

  // Strap pins cross in through three flops; second and third must agree
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gang_sync_reg  <= 3'h0;
      pm_sync_reg    <= 3'h0;
      strap_fill_reg <= 3'h0;
    end else begin
      gang_sync_reg  <= {gang_sync_reg[1:0], gang_select_strap_pin};
      pm_sync_reg    <= {pm_sync_reg[1:0], power_mgmt_strap_pin};
      strap_fill_reg <= {strap_fill_reg[1:0], 1'b1};
    end
  end

  // Capture waits until both straps have settled after release
  wire straps_stable = (gang_sync_reg[1] == gang_sync_reg[2]) &&
                       (pm_sync_reg[1] == pm_sync_reg[2]);
  // Chain reset zeros look settled too, so wait until it has filled
  wire strap_take = strap_pending_reg && strap_fill_reg[2] &&
                    straps_stable && ee_first_seen_reg == 1'b0;

  wire otp_override = (otp_vid != 16'h0000) && (otp_pid != 16'h0000);

  // EEPROM byte at offset 0 decides whether later bytes are taken
  wire ee_sig_byte = eeprom_mode && ee_en && ee_addr == HPIDC_OFF_SIGNATURE;
  wire ee_load = eeprom_mode && ee_en && sig_ok_reg;
  wire host_wr = !eeprom_mode && wr_en;
  wire        any_wr   = ee_load || host_wr;
  wire [7:0]  w_addr   = ee_load ? ee_addr : wr_addr;
  wire [7:0]  w_data   = ee_load ? ee_data : wr_data;
  wire wr_pid_low  = any_wr && w_addr == HPIDC_OFF_PID_LOW && !otp_override;
  wire wr_pid_high = any_wr && w_addr == HPIDC_OFF_PID_HIGH && !otp_override;
  wire wr_feat     = any_wr && w_addr == HPIDC_OFF_FEATURE;
  // Read-only bits keep their stored value on write
  wire [7:0] feat_merge = (w_data & HPIDC_FEAT_WMASK) |
                          (feat_reg & ~HPIDC_FEAT_WMASK);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pid_low_reg  <= HPIDC_PID_LOW_RST;
      pid_high_reg <= HPIDC_PID_HIGH_RST;
    end else begin
      if (wr_pid_low) begin
        pid_low_reg <= w_data;
      end
      if (wr_pid_high) begin
        pid_high_reg <= w_data;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      feat_reg          <= HPIDC_FEAT_RST;
      strap_pending_reg <= 1'b1;
    end else if (wr_feat) begin
      feat_reg          <= feat_merge;
      strap_pending_reg <= 1'b0;
    end else if (strap_take) begin
      feat_reg[HPIDC_BIT_GANG]  <= gang_sync_reg[2];
      feat_reg[HPIDC_BIT_PMOFF] <= pm_sync_reg[2];
      strap_pending_reg         <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sig_ok_reg        <= 1'b0;
      ee_first_seen_reg <= 1'b0;
    end else if (ee_sig_byte) begin
      sig_ok_reg        <= (ee_data == HPIDC_SIGNATURE_VAL);
      ee_first_seen_reg <= 1'b1;
    end
  end

  // Sticky until reset or upstream disconnect; the event wins a tie
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flpma_reg <= 1'b0;
    end else if (force_lpm_accept_seen) begin
      flpma_reg <= 1'b1;
    end else if (upstream_disconnect) begin
      flpma_reg <= 1'b0;
    end
  end

  wire [7:0] pid_low_view  = otp_override ? otp_pid[7:0]  : pid_low_reg;
  wire [7:0] pid_high_view = otp_override ? otp_pid[15:8] : pid_high_reg;
  wire [7:0] feat_view = {feat_reg[7:5], 1'b1,
                          feat_reg[3:1], 1'b0};

  always_comb begin
    unique case (rd_addr)
      HPIDC_OFF_PID_LOW:  rd_next = pid_low_view;
      HPIDC_OFF_PID_HIGH: rd_next = pid_high_view;
      HPIDC_OFF_FEATURE:  rd_next = feat_view;
      default:            rd_next = 8'h00;
    endcase
  end

  wire pm_on = !feat_reg[HPIDC_BIT_PMOFF];
  wire ganged = feat_reg[HPIDC_BIT_GANG];
  wire [NPORT-1:0] pwr_next;
  genvar gi;
  generate
    for (gi = 0; gi < NPORT; gi++) begin : g_pwr
      // Ganged hub powers all from the port-1 pin, which asserts on any request
      if (gi == 0) begin : g_first
        assign pwr_next[gi] = pm_on &&
          (ganged ? |port_power_req : port_power_req[gi]);
      end else begin : g_rest
        assign pwr_next[gi] = pm_on && !ganged && port_power_req[gi];
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_data                 <= 8'h00;
      ss_pid_low              <= 8'h00;
      hs_pid_low              <= 8'h00;
      pid_high                <= 8'h00;
      string_write_enable     <= 1'b0;
      serial_write_enable     <= 1'b0;
      u1u2_allowed            <= 1'b0;
      overcurrent_report_en   <= 1'b0;
      port_power_control_pins <= '0;
    end else begin
      rd_data                 <= rd_next;
      ss_pid_low              <= pid_low_view;
      hs_pid_low              <= pid_low_view ^ HPIDC_HS_XOR_MASK;
      pid_high                <= pid_high_view;
      string_write_enable     <= feat_reg[HPIDC_BIT_STRING];
      serial_write_enable     <= feat_reg[HPIDC_BIT_SERIAL];
      u1u2_allowed            <= !feat_reg[HPIDC_BIT_LPDIS] ||
                                 flpma_reg;
      overcurrent_report_en   <= pm_on;
      port_power_control_pins <= pwr_next;
    end
  end

  property p_hs_xor;
    @(posedge clk) disable iff (!rstn)
      1'b1 |=> hs_pid_low == (ss_pid_low ^ 8'h02);
  endproperty
  a_hs_xor: assert property (p_hs_xor) else $error("hs id mismatch");

  property p_ss_pid;
    @(posedge clk) disable iff (!rstn)
      1'b1 |=> ss_pid_low == $past(pid_low_view);
  endproperty
  a_ss_pid: assert property (p_ss_pid) else $error("ss id wrong");

  property p_otp_hold;
    @(posedge clk) disable iff (!rstn)
      otp_override |=> pid_low_reg == $past(pid_low_reg);
  endproperty
  a_otp_hold: assert property (p_otp_hold)
    else $error("otp write taken");

  property p_rsv_hi;
    @(posedge clk) disable iff (!rstn)
      rd_addr == HPIDC_OFF_FEATURE |=> rd_data[4] && !rd_data[0];
  endproperty
  a_rsv_hi: assert property (p_rsv_hi)
    else $error("reserved bits");

  property p_lp_dis;
    @(posedge clk) disable iff (!rstn)
      feat_reg[HPIDC_BIT_LPDIS] && !flpma_reg ##1 feat_reg[HPIDC_BIT_LPDIS] &&
        !flpma_reg |-> !u1u2_allowed;
  endproperty
  a_lp_dis: assert property (p_lp_dis) else $error("u1u2 not off");

  property p_flpma;
    @(posedge clk) disable iff (!rstn)
      force_lpm_accept_seen |=> ##1 u1u2_allowed;
  endproperty
  a_flpma: assert property (p_flpma) else $error("flpma ignored");

  property p_sig_bad;
    @(posedge clk) disable iff (!rstn)
      ee_sig_byte && ee_data != 8'h55 |=> !sig_ok_reg;
  endproperty
  a_sig_bad: assert property (p_sig_bad) else $error("bad sig loads");

  property p_host_ee;
    @(posedge clk) disable iff (!rstn)
      eeprom_mode && !ee_en |=> $stable(feat_reg) || $past(strap_take);
  endproperty
  a_host_ee: assert property (p_host_ee)
    else $error("host wrote in ee");

  property p_gang;
    @(posedge clk) disable iff (!rstn)
      ganged && pm_on && $stable(ganged) |=> port_power_control_pins[0] ==
        $past(|port_power_req);
  endproperty
  a_gang: assert property (p_gang) else $error("gang power");

  property p_str_en;
    @(posedge clk) disable iff (!rstn)
      1'b1 |=> string_write_enable == $past(feat_reg[7]) &&
        serial_write_enable == $past(feat_reg[6]);
  endproperty
  a_str_en: assert property (p_str_en)
    else $error("write enable");
endmodule // hpidc_bank

/* test/hpidc_ee_model.sv */
// Serial configuration memory model that streams its image into the bank
`timescale 1ns/1ps
module hpidc_ee_model (
  input  wire logic       clk,
  input  wire logic       start,
  input  wire logic [7:0] sig,
  output logic            ee_en,
  output logic [7:0]      ee_addr,
  output logic [7:0]      ee_data,
  output logic            done
);
  logic [7:0] img [0:5];
  initial begin
    ee_en = 1'b0;
    ee_addr = 8'h00;
    ee_data = 8'h00;
    done = 1'b0;
  end
  // Bit 1 of the feature byte left at its default
  always @(posedge start) begin
    img = '{sig, 8'h01, 8'h02, 8'h11, 8'h22, 8'h24};
    done = 1'b0;
    // Signature byte goes first, then data
    for (int i = 0; i < 6; i++) begin
      @(negedge clk);
      ee_en = 1'b1;
      ee_addr = i[7:0];
      ee_data = img[i];
    end
    @(negedge clk);
    ee_en = 1'b0;
    // Released lines must not look like a held byte
    ee_addr = ~ee_addr;
    ee_data = ~ee_data;
    done = 1'b1;
  end
endmodule // hpidc_ee_model

/* test/hub_product_id_and_device_config_tb_top.sv */
// Self-checking bench for the id and feature configuration bank
`timescale 1ns/1ps
module hub_product_id_and_device_config_tb_top;
  import hpidc_pkg::*;
  logic        clk, rstn, eeprom_mode, wr_en, ee_en, start, done;
  logic        gang_select_strap_pin, power_mgmt_strap_pin;
  logic        force_lpm_accept_seen, upstream_disconnect;
  logic        string_write_enable, serial_write_enable;
  logic        u1u2_allowed, overcurrent_report_en;
  logic [7:0]  wr_addr, wr_data, ee_addr, ee_data, rd_addr, rd_data, sig;
  logic [7:0]  ss_pid_low, hs_pid_low, pid_high;
  logic [15:0] otp_vid, otp_pid;
  logic [1:0]  port_power_req, port_power_control_pins;
  int          n_errors, tests_run;

  hpidc_bank #(.NPORT(2)) hpidc_bank_inst (
    .clk                     (clk),
    .rstn                    (rstn),
    .eeprom_mode             (eeprom_mode),
    .wr_en                   (wr_en),
    .wr_addr                 (wr_addr),
    .wr_data                 (wr_data),
    .ee_en                   (ee_en),
    .ee_addr                 (ee_addr),
    .ee_data                 (ee_data),
    .rd_addr                 (rd_addr),
    .rd_data                 (rd_data),
    .otp_vid                 (otp_vid),
    .otp_pid                 (otp_pid),
    .gang_select_strap_pin   (gang_select_strap_pin),
    .power_mgmt_strap_pin    (power_mgmt_strap_pin),
    .force_lpm_accept_seen   (force_lpm_accept_seen),
    .upstream_disconnect     (upstream_disconnect),
    .port_power_req          (port_power_req),
    .ss_pid_low              (ss_pid_low),
    .hs_pid_low              (hs_pid_low),
    .pid_high                (pid_high),
    .string_write_enable     (string_write_enable),
    .serial_write_enable     (serial_write_enable),
    .u1u2_allowed            (u1u2_allowed),
    .overcurrent_report_en   (overcurrent_report_en),
    .port_power_control_pins (port_power_control_pins)
  );
  hpidc_ee_model hpidc_ee_model_inst (
    .clk     (clk),
    .start   (start),
    .sig     (sig),
    .ee_en   (ee_en),
    .ee_addr (ee_addr),
    .ee_data (ee_data),
    .done    (done)
  );

  always #5 clk = ~clk;

  task end_sim;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    {wr_en, wr_addr, wr_data} = {1'b1, a, d};
    @(negedge clk);
    wr_en = 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    rd_addr = a;
    @(negedge clk);
    chk(rd_data, e);
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task do_reset;
    rstn = 1'b0;
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    // Straps need a few edges to settle
    repeat (5) @(negedge clk);
  endtask
  task load(input logic [7:0] s);
    int k;
    sig = s;
    pulse(start);
    k = 0;
    while (done !== 1'b1 && k < 50) begin
      @(negedge clk);
      k++;
    end
    if (k >= 50) begin
      n_errors++;
      $display("ERROR at %0t: load hung", $time);
      end_sim();
    end
  endtask

  initial begin
    {clk, rstn, eeprom_mode, wr_en, start, sig} = '0;
    {wr_addr, wr_data, rd_addr, otp_vid, otp_pid} = '0;
    {force_lpm_accept_seen, upstream_disconnect} = '0;
    {gang_select_strap_pin, power_mgmt_strap_pin} = 2'b10;
    port_power_req = 2'b10;
    do_reset();
    rd(HPIDC_OFF_PID_LOW, HPIDC_PID_LOW_RST);
    rd(HPIDC_OFF_PID_HIGH, HPIDC_PID_HIGH_RST);
    rd(HPIDC_OFF_FEATURE, 8'h18);
    rd(8'h40, 8'h00);
    chk(ss_pid_low, HPIDC_PID_LOW_RST);
    chk(hs_pid_low, HPIDC_PID_LOW_RST ^ 8'h02);
    chk(overcurrent_report_en, 8'h01);
    chk(port_power_control_pins, 8'h01);
    $display("test reset done");
    // Bit 1 kept at its default
    wr(HPIDC_OFF_FEATURE, 8'hfd);
    rd(HPIDC_OFF_FEATURE, 8'hfc);
    chk(string_write_enable, 8'h01);
    chk(serial_write_enable, 8'h01);
    chk(u1u2_allowed, 8'h00);
    chk(overcurrent_report_en, 8'h00);
    chk(port_power_control_pins, 8'h00);
    pulse(force_lpm_accept_seen);
    chk(u1u2_allowed, 8'h01);
    pulse(upstream_disconnect);
    chk(u1u2_allowed, 8'h00);
    wr(HPIDC_OFF_FEATURE, 8'h00);
    rd(HPIDC_OFF_FEATURE, 8'h10);
    chk({string_write_enable, serial_write_enable}, 8'h00);
    chk(u1u2_allowed, 8'h01);
    chk(port_power_control_pins, 8'h02);
    $display("test feature done");
    wr(HPIDC_OFF_PID_LOW, 8'ha5);
    wr(HPIDC_OFF_PID_HIGH, 8'hc3);
    rd(HPIDC_OFF_PID_HIGH, 8'hc3);
    chk(pid_high, 8'hc3);
    chk(ss_pid_low, 8'ha5);
    chk(hs_pid_low, 8'ha7);
    {otp_vid, otp_pid} = 32'h1234_abcd;
    wr(HPIDC_OFF_PID_LOW, 8'h00);
    rd(HPIDC_OFF_PID_LOW, 8'hcd);
    rd(HPIDC_OFF_PID_HIGH, 8'hab);
    chk(pid_high, 8'hab);
    {otp_vid, otp_pid} = 32'h0000_abcd;
    rd(HPIDC_OFF_PID_LOW, 8'ha5);
    $display("test ids done");
    eeprom_mode = 1'b1;
    do_reset();
    load(HPIDC_SIGNATURE_VAL);
    rd(HPIDC_OFF_PID_LOW, 8'h11);
    rd(HPIDC_OFF_PID_HIGH, 8'h22);
    wr(HPIDC_OFF_FEATURE, 8'h00);
    rd(HPIDC_OFF_FEATURE, 8'h34);
    chk({u1u2_allowed, overcurrent_report_en}, 8'h00);
    {gang_select_strap_pin, power_mgmt_strap_pin} = 2'b00;
    do_reset();
    load(8'haa);
    rd(HPIDC_OFF_PID_LOW, HPIDC_PID_LOW_RST);
    rd(HPIDC_OFF_FEATURE, 8'h10);
    $display("test eeprom done");
    end_sim();
  end
endmodule // hub_product_id_and_device_config_tb_top
